// ==== lpf_cfg.svh ====
// constants of the pixel fetch datapath: register offsets, fields, reset values, timing
// assumes inclusion by the design modules lpf_fifo, lpf_serializer and lpf_datapath
`ifndef LPF_CFG_SVH
`define LPF_CFG_SVH
`define LPF_REG_BASE_U      8'h00
`define LPF_REG_BASE_L      8'h04
`define LPF_REG_FRAME_CFG   8'h08
`define LPF_REG_FIFO_CFG    8'h0c
`define LPF_REG_PANEL_CTL   8'h10
`define LPF_REG_CONTROL     8'h14
`define LPF_REG_STATUS      8'h18
`define LPF_FRMSZ_MSB       22
`define LPF_BURST_LSB       24
`define LPF_BURST_MSB       25
`define LPF_FIFO_DEPTH      512
`define LPF_FIFO_AW         9
`define LPF_THR_RESET       10'h1fd
`define LPF_LAT_TFT         9
`define LPF_CPD_TFT         1
`endif

// ==== lpf_pkg.sv ====
// types shared by the pixel fetch datapath modules
// assumes lpf_cfg.svh defines the constants
package lpf_pkg;
  typedef enum logic [1:0] {LPF_BURST_INCR, LPF_BURST_4, LPF_BURST_8, LPF_BURST_16} lpf_burst_e;
  typedef enum logic [2:0] {LPF_BPP_1, LPF_BPP_2, LPF_BPP_4, LPF_BPP_8, LPF_BPP_16, LPF_BPP_24} lpf_bpp_e;
  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hburst;
    logic [2:0]  hsize;
    logic        hwrite;
  } lpf_ahb_req_s;
  typedef struct packed {
    logic       dual_scan;
    logic       big_endian;
    logic       stn;
    logic       stn_color;
    logic [1:0] bus_width_sel;
    lpf_bpp_e   bpp;
  } lpf_panel_cfg_s;
endpackage

// ==== lpf_fifo.sv ====
// one input buffer of the datapath; push and pop with honest full and empty
// assumes push is never asserted while full (fetch stalls on full)
`timescale 1ns/1ps
`include "lpf_cfg.svh"
module lpf_fifo #(
  parameter int DEPTH = `LPF_FIFO_DEPTH,
  parameter int AW    = `LPF_FIFO_AW
) (
  input  wire logic          clk_in,
  input  wire logic          sys_rst_in,
  input  wire logic          flush_in,
  input  wire logic          push_in,
  input  wire logic [31:0]   data_in,
  input  wire logic          pop_in,
  output logic      [31:0]   data_out,
  output logic      [AW:0]   count_out,
  output logic               full_out,
  output logic               empty_out
);
  logic [31:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic do_push;
  logic do_pop;
  assign full_out  = (count_out >= (AW+1)'(DEPTH));
  assign empty_out = (count_out == '0);
  assign do_push   = push_in && !full_out;
  assign do_pop    = pop_in && !empty_out;
  assign data_out  = mem[rd_ptr];
  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem[wr_ptr] <= data_in;
    end
  end
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count_out <= '0;
    end else if (flush_in) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count_out <= '0;
    end else begin
      if (do_push) wr_ptr <= wr_ptr + 1'b1;
      if (do_pop) rd_ptr <= rd_ptr + 1'b1;
      count_out <= count_out + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
  no_overflow_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    full_out |=> count_out <= $past(count_out)) else $error("fifo grew while full");
endmodule

// ==== lpf_serializer.sv ====
// unpacks words into pixels of 1..24 bits in either memory ordering
// assumes a word source that shows the head word combinationally
`timescale 1ns/1ps
`include "lpf_cfg.svh"
module lpf_serializer (
  input  wire logic               clk_in,
  input  wire logic               sys_rst_in,
  input  wire logic               flush_in,
  input  wire lpf_pkg::lpf_bpp_e  bpp_in,
  input  wire logic               big_endian_in,
  input  wire logic               word_valid_in,
  input  wire logic [31:0]        word_in,
  output logic                    word_pop_out,
  input  wire logic               pixel_take_in,
  output logic                    pixel_valid_out,
  output logic      [23:0]        pixel_out
);
  import lpf_pkg::*;
  // 64-bit holding register: bits are consumed from one end, words enter behind them
  logic [63:0] hold;
  logic [6:0]  fill;
  logic [4:0]  width;
  logic        take;
  logic [63:0] after_take;
  logic [6:0]  fill_after;
  function automatic logic [4:0] bpp_width(input lpf_bpp_e b);
    unique case (b)
      LPF_BPP_1:  bpp_width = 5'd1;
      LPF_BPP_2:  bpp_width = 5'd2;
      LPF_BPP_4:  bpp_width = 5'd4;
      LPF_BPP_8:  bpp_width = 5'd8;
      LPF_BPP_16: bpp_width = 5'd16;
      default:    bpp_width = 5'd24;
    endcase
  endfunction
  assign width = bpp_width(bpp_in);
  assign pixel_valid_out = (fill >= 7'(width));
  assign take = pixel_take_in && pixel_valid_out;
  always_comb begin
    after_take = hold;
    fill_after = fill;
    if (take) begin
      fill_after = fill - 7'(width);
      after_take = big_endian_in ? (hold << width) : (hold >> width);
    end
  end
  assign word_pop_out = word_valid_in && (fill_after <= 7'd32);
  always_comb begin
    pixel_out = '0;
    for (int i = 0; i < 24; i++) begin
      if (i < int'(width)) begin
        // big endian: first pixel in the top bits (hold bit 63, word bit 31, at 1 bpp); little: lowest bits
        pixel_out[i] = big_endian_in ? hold[64 - int'(width) + i] : hold[i];
      end
    end
  end
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hold <= '0;
      fill <= '0;
    end else if (flush_in) begin
      hold <= '0;
      fill <= '0;
    end else begin
      hold <= after_take;
      fill <= fill_after;
      if (word_pop_out) begin
        // 24-bit pixels straddle words because new bits append behind the remainder
        if (big_endian_in) hold <= after_take | ({word_in, 32'h0000_0000} >> fill_after);
        else hold <= after_take | ({32'h0000_0000, word_in} << fill_after);
        fill <= fill_after + 7'd32;
      end
    end
  end
  fill_bound_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    fill <= 7'd64) else $error("serializer over-filled");
endmodule

// ==== lpf_datapath.sv ====
// top of the display pixel fetch: AHB master DMA with two channels, two input buffers,
// serializer and Avalon-MM register slave; single clock domain
// assumes a palette/timing stage downstream that raises data_req_in and reads pixel_bus_out
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "lpf_cfg.svh"
module lpf_datapath #(
  parameter int FIFO_DEPTH = `LPF_FIFO_DEPTH,
  parameter int FIFO_AW    = `LPF_FIFO_AW
) (
  input  wire logic                  clk_in,
  input  wire logic                  sys_rst_in,
  // avalon-mm slave
  input  wire logic [7:0]            avs_address_in,
  input  wire logic                  avs_read_in,
  input  wire logic                  avs_write_in,
  input  wire logic [31:0]           avs_writedata_in,
  input  wire logic [3:0]            avs_byteenable_in,
  output logic      [31:0]           avs_readdata_out,
  output logic                       avs_waitrequest_out,
  // ahb master
  output lpf_pkg::lpf_ahb_req_s      ahb_req_out,
  input  wire logic                  ahb_hready_in,
  input  wire logic [1:0]            ahb_hresp_in,
  input  wire logic [31:0]           ahb_hrdata_in,
  // frame and pixel interface to the timing stage
  input  wire logic                  new_frame_in,
  input  wire logic                  data_req_in,
  output logic                       data_valid_out,
  output logic      [23:0]           pixel_bus_out,
  output logic                       end_of_frame_out
);
  import lpf_pkg::*;
  localparam int LAT_TFT = `LPF_LAT_TFT;
  localparam int CPD_TFT = `LPF_CPD_TFT;

  // ---------------- registers ----------------
  logic [31:0]    base_u;
  logic [31:0]    base_l;
  logic [22:0]    frame_word_count;
  lpf_burst_e     burst_length_sel;
  logic [9:0]     fifo_refill_threshold;
  lpf_panel_cfg_s panel_control_two;
  logic           enable;
  logic           bus_err;
  logic           eof_u;
  logic           eof_l;
  logic           acc;
  logic           wr_ok;
  logic           err_set;
  logic           err_clr;

  // one wait cycle, so read data always come from a flop
  logic rd_done;
  assign acc = (avs_read_in || avs_write_in) && !rd_done;
  assign avs_waitrequest_out = acc;
  // a write lands only at the edge where waitrequest is low, as the master sees it
  assign wr_ok = avs_write_in && rd_done && (avs_byteenable_in == 4'hf);

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) rd_done <= 1'b0;
    else rd_done <= acc;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      base_u                <= '0;
      base_l                <= '0;
      frame_word_count      <= '0;
      burst_length_sel      <= LPF_BURST_INCR;
      fifo_refill_threshold <= `LPF_THR_RESET;
      panel_control_two     <= '0;
      enable                <= 1'b0;
    end else if (wr_ok) begin
      unique case (avs_address_in)
        `LPF_REG_BASE_U:    base_u <= {avs_writedata_in[31:2], 2'b00};
        `LPF_REG_BASE_L:    base_l <= {avs_writedata_in[31:2], 2'b00};
        `LPF_REG_FRAME_CFG: begin
          frame_word_count <= avs_writedata_in[`LPF_FRMSZ_MSB:0];
          burst_length_sel <= lpf_burst_e'(avs_writedata_in[`LPF_BURST_MSB:`LPF_BURST_LSB]);
        end
        `LPF_REG_FIFO_CFG:  fifo_refill_threshold <= avs_writedata_in[9:0];
        `LPF_REG_PANEL_CTL: begin
          panel_control_two.bpp <= (avs_writedata_in[2:0] > 3'd5) ? LPF_BPP_24 : lpf_bpp_e'(avs_writedata_in[2:0]);
          panel_control_two.big_endian    <= avs_writedata_in[3];
          panel_control_two.dual_scan     <= avs_writedata_in[4];
          panel_control_two.stn           <= avs_writedata_in[5];
          panel_control_two.stn_color     <= avs_writedata_in[6];
          panel_control_two.bus_width_sel <= avs_writedata_in[9:8];
        end
        `LPF_REG_CONTROL:   enable <= avs_writedata_in[0];
        default: ;
      endcase
    end
  end

  assign err_clr = wr_ok && (avs_address_in == `LPF_REG_STATUS) && avs_writedata_in[0];
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) bus_err <= 1'b0;
    else if (err_set) bus_err <= 1'b1;
    else if (err_clr) bus_err <= 1'b0;
  end

  logic [FIFO_AW:0] cnt_u;
  logic [FIFO_AW:0] cnt_l;
  logic             busy;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) avs_readdata_out <= '0;
    else if (avs_read_in && acc) begin
      unique case (avs_address_in)
        `LPF_REG_BASE_U:    avs_readdata_out <= base_u;
        `LPF_REG_BASE_L:    avs_readdata_out <= base_l;
        `LPF_REG_FRAME_CFG: avs_readdata_out <= {6'h00, burst_length_sel, 1'b0, frame_word_count};
        `LPF_REG_FIFO_CFG:  avs_readdata_out <= {22'h000000, fifo_refill_threshold};
        `LPF_REG_PANEL_CTL: avs_readdata_out <= {22'h000000, panel_control_two.bus_width_sel, 1'b0,
                                                 panel_control_two.stn_color, panel_control_two.stn,
                                                 panel_control_two.dual_scan, panel_control_two.big_endian,
                                                 panel_control_two.bpp};
        `LPF_REG_CONTROL:   avs_readdata_out <= {31'h00000000, enable};
        `LPF_REG_STATUS:    avs_readdata_out <= {6'h00, 10'(cnt_l), 2'b00, 10'(cnt_u), eof_l, eof_u, busy, bus_err};
        default:            avs_readdata_out <= '0;
      endcase
    end
  end

  // ---------------- channels and control ----------------
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} lpf_dma_st_e;
  lpf_dma_st_e st;
  logic [31:0] ptr_u;
  logic [31:0] ptr_l;
  logic [22:0] left_u;
  logic [22:0] left_l;
  logic        sel_l;
  logic [4:0]  beats;
  logic [4:0]  beat_no;
  logic        need_u;
  logic        need_l;
  logic        push_u;
  logic        push_l;
  logic        full_u;
  logic        full_l;
  logic        dual;
  logic [22:0] left_sel;
  logic [4:0]  burst_beats;
  logic        data_beat;
  logic        stall;

  assign dual = panel_control_two.dual_scan;
  assign need_u = enable && (cnt_u < (FIFO_AW+1)'(fifo_refill_threshold)) && (left_u != '0);
  assign need_l = enable && dual && (cnt_l < (FIFO_AW+1)'(fifo_refill_threshold)) && (left_l != '0);
  assign busy = (st != ST_IDLE);
  assign left_sel = sel_l ? left_l : left_u;
  always_comb begin
    unique case (burst_length_sel)
      LPF_BURST_4:  burst_beats = 5'd4;
      LPF_BURST_8:  burst_beats = 5'd8;
      LPF_BURST_16: burst_beats = 5'd16;
      default:      burst_beats = 5'd16;
    endcase
  end
  // each address phase is held off while the target buffer is full
  assign stall = sel_l ? full_l : full_u;
  assign data_beat = (st == ST_DATA) && ahb_hready_in;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st      <= ST_IDLE;
      sel_l   <= 1'b0;
      beats   <= '0;
      beat_no <= '0;
    end else begin
      unique case (st)
        ST_IDLE: if (need_u || need_l) begin
          sel_l   <= !need_u;
          beats   <= ((!need_u ? left_l : left_u) < 23'(burst_beats)) ? 5'((!need_u ? left_l : left_u)) : burst_beats;
          beat_no <= '0;
          st      <= ST_ADDR;
        end
        ST_ADDR: if (ahb_hready_in && !stall) st <= ST_DATA;
        ST_DATA: if (ahb_hready_in) begin
          beat_no <= beat_no + 5'd1;
          if (beat_no + 5'd1 == beats || ahb_hresp_in != 2'b00) st <= ST_IDLE;
          else if (stall) st <= ST_ADDR;
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  assign err_set = data_beat && (ahb_hresp_in != 2'b00);

  // one AHB word per beat; the undefined-length burst is capped at 16 beats, the longest fixed length
  always_comb begin
    ahb_req_out        = '0;
    ahb_req_out.hsize  = 3'b010;
    // in a data phase the pipelined address phase already names the following word
    ahb_req_out.haddr  = (sel_l ? ptr_l : ptr_u) + ((st == ST_DATA) ? 32'd4 : 32'd0);
    ahb_req_out.hwrite = 1'b0;
    unique case (burst_length_sel)
      LPF_BURST_4:  ahb_req_out.hburst = 3'b011;
      LPF_BURST_8:  ahb_req_out.hburst = 3'b101;
      LPF_BURST_16: ahb_req_out.hburst = 3'b111;
      default:      ahb_req_out.hburst = 3'b001;
    endcase
    if (st == ST_ADDR && !stall) ahb_req_out.htrans = (beat_no == '0) ? 2'b10 : 2'b11;
    if ((st == ST_DATA) && (beat_no + 5'd1 < beats) && !stall) ahb_req_out.htrans = 2'b11;
  end

  assign push_u = data_beat && !sel_l && (ahb_hresp_in == 2'b00);
  assign push_l = data_beat && sel_l && (ahb_hresp_in == 2'b00);

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ptr_u  <= '0;
      left_u <= '0;
      eof_u  <= 1'b0;
    end else if (new_frame_in) begin
      ptr_u  <= base_u;
      left_u <= frame_word_count;
      eof_u  <= 1'b0;
    end else if (push_u) begin
      ptr_u  <= ptr_u + 32'd4;
      left_u <= left_u - 23'd1;
      eof_u  <= (left_u == 23'd1);
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ptr_l  <= '0;
      left_l <= '0;
      eof_l  <= 1'b0;
    end else if (new_frame_in) begin
      ptr_l  <= base_l;
      left_l <= dual ? frame_word_count : 23'd0;
      eof_l  <= 1'b0;
    end else if (push_l) begin
      ptr_l  <= ptr_l + 32'd4;
      left_l <= left_l - 23'd1;
      eof_l  <= (left_l == 23'd1);
    end
  end

  assign end_of_frame_out = eof_u && (!dual || eof_l);

  // ---------------- input buffers ----------------
  logic [31:0] q_u;
  logic [31:0] q_l;
  logic        empty_u;
  logic        empty_l;
  logic        pop_u;
  logic        pop_l;
  logic        pop_w;
  logic        src_l;

  // single scan uses the upper buffer alone; its depth is the effective size either way
  lpf_fifo #(.DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo_u (
    .clk_in    (clk_in),
    .sys_rst_in(sys_rst_in),
    .flush_in  (new_frame_in),
    .push_in   (push_u),
    .data_in   (ahb_hrdata_in),
    .pop_in    (pop_u),
    .data_out  (q_u),
    .count_out (cnt_u),
    .full_out  (full_u),
    .empty_out (empty_u)
  );
  lpf_fifo #(.DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo_l (
    .clk_in    (clk_in),
    .sys_rst_in(sys_rst_in),
    .flush_in  (new_frame_in),
    .push_in   (push_l),
    .data_in   (ahb_hrdata_in),
    .pop_in    (pop_l),
    .data_out  (q_l),
    .count_out (cnt_l),
    .full_out  (full_l),
    .empty_out (empty_l)
  );

  // dual scan alternates words from upper and lower panels
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) src_l <= 1'b0;
    else if (new_frame_in) src_l <= 1'b0;
    else if (pop_w && dual) src_l <= !src_l;
  end
  assign pop_u = pop_w && !(dual && src_l);
  assign pop_l = pop_w && dual && src_l;

  // ---------------- serializer and output ----------------
  logic        pix_valid;
  logic [23:0] pix;
  logic        take;
  lpf_serializer u_ser (
    .clk_in         (clk_in),
    .sys_rst_in     (sys_rst_in),
    .flush_in       (new_frame_in),
    .bpp_in         (panel_control_two.bpp),
    .big_endian_in  (panel_control_two.big_endian),
    .word_valid_in  ((dual && src_l) ? !empty_l : !empty_u),
    .word_in        ((dual && src_l) ? q_l : q_u),
    .word_pop_out   (pop_w),
    .pixel_take_in  (take),
    .pixel_valid_out(pix_valid),
    .pixel_out      (pix)
  );

  // spacing counter: TFT one cycle per datum, STN spacing from bus width, colour mode and dual scan
  logic [4:0] gap;
  logic [4:0] cpd;
  always_comb begin
    cpd = 5'(CPD_TFT);
    if (panel_control_two.stn) begin
      unique case (panel_control_two.bus_width_sel)
        2'd0:    cpd = panel_control_two.stn_color ? 5'd2 : 5'd4;
        2'd1:    cpd = panel_control_two.stn_color ? (dual ? 5'd4 : 5'd3) : 5'd8;
        default: cpd = panel_control_two.stn_color ? 5'd6 : 5'd16;
      endcase
    end
  end
  assign take = data_req_in && pix_valid && (gap == '0);
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) gap <= '0;
    else if (take) gap <= cpd - 5'd1;
    else if (gap != '0) gap <= gap - 5'd1;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pixel_bus_out  <= '0;
      data_valid_out <= 1'b0;
    end else begin
      data_valid_out <= take;
      if (take) pixel_bus_out <= pix;
    end
  end

  spacing_min_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    take && panel_control_two.stn && panel_control_two.bus_width_sel == 2'd2 && !panel_control_two.stn_color
    |=> !take [*8]) else $error("stn output spaced too closely");
  out_follows_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    data_valid_out |-> $past(data_req_in)) else $error("output without request");
  reload_base_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    new_frame_in |=> ptr_u == $past(base_u) && left_u == $past(frame_word_count)) else $error("no reload");
  lower_idle_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !dual |-> !push_l) else $error("lower channel used in single scan");
  push_space_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    push_u |-> !full_u) else $error("push into full buffer");
  word_write_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    avs_write_in && rd_done && avs_byteenable_in != 4'hf && avs_address_in == `LPF_REG_CONTROL
    |=> enable == $past(enable)) else $error("partial write took effect");
  ptr_step_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    push_u && !new_frame_in |=> ptr_u == $past(ptr_u) + 32'd4) else $error("address not stepped");
  wait_once_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    avs_waitrequest_out |=> !avs_waitrequest_out) else $error("wait longer than one cycle");
endmodule

// ==== lpf_ahb_mem.sv ====
// behavioural frame memory on the far side of the ahb master port
// assumes one master; word content is a fixed function of its address
`timescale 1ns/1ps
module lpf_ahb_mem import lpf_pkg::*; (
  input  wire logic               clk_in,
  input  wire logic               sys_rst_in,
  input  wire lpf_pkg::lpf_ahb_req_s req_in,
  output logic                    hready_out,
  output logic      [1:0]         hresp_out,
  output logic      [31:0]        hrdata_out
);
  logic        dphase;
  logic        slow;
  logic [31:0] daddr;
  logic [31:0] last;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      dphase <= 1'b0;
      daddr  <= 32'h0;
      slow   <= 1'b0;
      last   <= 32'h0;
    end else begin
      // random wait states so the fetch must hold its address phase
      slow <= ($urandom % 3) == 0;
      if (hready_out) begin
        dphase <= req_in.htrans[1];
        daddr  <= req_in.haddr;
      end
      if (hready_out && dphase) begin
        last <= hrdata_out;
      end
    end
  end
  assign hready_out = !(dphase && slow);
  assign hresp_out  = 2'h0;
  // outside a finished beat the bus shows garbage, never the last word
  assign hrdata_out = (dphase && hready_out) ? {daddr[15:0] ^ 16'hc3a5, daddr[15:0]} : ~last;
endmodule

// ==== lpf_datapath_bench.sv ====
// self-checking bench: registers over avalon, frames fetched from lpf_ahb_mem, pixels against a bit-queue model
// assumes a 64-word buffer build of the datapath and tft timing (one cycle per data)
`timescale 1ns/1ps
module lpf_datapath_bench;
  import lpf_pkg::*;
  localparam int DEPTH = 64;
  localparam int NW    = 16;
  logic clk_in = 1'b0, sys_rst_in = 1'b1, avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic [7:0] avs_address_in = 8'h0;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, hrdata, q;
  logic [3:0] avs_byteenable_in = 4'hf;
  logic avs_waitrequest_out, hready, data_valid_out, end_of_frame_out;
  logic new_frame_in = 1'b0, data_req_in = 1'b0, run_req = 1'b0, req_q = 1'b0;
  logic [1:0] hresp;
  logic [23:0] pixel_bus_out;
  lpf_ahb_req_s ahb_req;
  int bad_count = 0, checks_done = 0;
  logic [23:0] got[$], exp[$];
  lpf_datapath #(.FIFO_DEPTH(DEPTH), .FIFO_AW(6)) lpf_datapath_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out), .ahb_req_out(ahb_req),
    .ahb_hready_in(hready), .ahb_hresp_in(hresp), .ahb_hrdata_in(hrdata), .new_frame_in(new_frame_in),
    .data_req_in(data_req_in), .data_valid_out(data_valid_out), .pixel_bus_out(pixel_bus_out),
    .end_of_frame_out(end_of_frame_out));
  lpf_ahb_mem lpf_ahb_mem_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .req_in(ahb_req), .hready_out(hready),
    .hresp_out(hresp), .hrdata_out(hrdata));
  initial begin
    forever #2 clk_in = ~clk_in;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_address_in <= a;
    avs_read_in <= !wr;
    avs_write_in <= wr;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 20);
    if (n >= 20) bad_count++;
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  // random pacing of the timing stage; pixels are sampled mid-cycle where they have settled
  always @(posedge clk_in) data_req_in <= run_req && ($urandom % 4 != 0);
  always @(negedge clk_in) begin
    if (data_valid_out === 1'b1) begin
      got.push_back(pixel_bus_out);
      check(req_q, 1'b1);
    end
    req_q = data_req_in;
  end
  task automatic run_frame(input int bsel, input int bw_sel, input logic big, input logic dual);
    int bw, bl, n, i, j, w, v;
    logic [31:0] word, a;
    int bits[$];
    bw = (bw_sel == 5) ? 24 : (1 << bw_sel);
    bl = (bsel == 0) ? 16 : (4 << (bsel - 1));
    av(1, 8'h10, {27'h0, dual, big, bw_sel[2:0]}, 4'hf);
    av(1, 8'h08, {6'h0, bsel[1:0], 24'(NW)}, 4'hf);
    av(1, 8'h0c, 32'(DEPTH - (2 * bl + 3)), 4'hf);
    av(1, 8'h00, 32'h1000 + 32'(bsel * 32'h100), 4'hf);
    av(1, 8'h04, 32'h8000, 4'hf);
    for (w = 0; w < (dual ? 2 * NW : NW); w++) begin
      a = dual ? ((w % 2) ? 32'h8000 + 32'(4 * (w / 2)) : 32'h1000 + 32'(bsel * 32'h100 + 4 * (w / 2)))
               : 32'h1000 + 32'(bsel * 32'h100 + 4 * w);
      word = {a[15:0] ^ 16'hc3a5, a[15:0]};
      for (i = 0; i < 32; i++) bits.push_back(big ? word[31 - i] : word[i]);
    end
    while (bits.size() >= bw) begin
      v = 0;
      for (j = 0; j < bw; j++) v = big ? ((v << 1) | bits.pop_front()) : (v | (bits.pop_front() << j));
      exp.push_back(24'(v));
    end
    got.delete();
    @(posedge clk_in);
    new_frame_in <= 1'b1;
    @(posedge clk_in);
    new_frame_in <= 1'b0;
    run_req <= 1'b1;
    n = 0;
    while (got.size() < exp.size() && n < 4000) begin
      @(posedge clk_in);
      n++;
    end
    repeat (4) @(posedge clk_in);
    run_req <= 1'b0;
    check(got.size(), exp.size());
    while (exp.size() > 0 && got.size() > 0) check(got.pop_front(), exp.pop_front());
    exp.delete();
    check(end_of_frame_out, 1'b1);
    av(0, 8'h18, 32'h0, 4'hf);
    check({q[3:2], q[0]}, {dual, 2'b10});
  endtask
  initial begin
    #200000;
    bad_count++;
    end_of_test();
  end
  initial begin
    void'($urandom(93));
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    av(0, 8'h0c, 32'h0, 4'hf);
    check(q, 32'h1fd);
    av(1, 8'h0c, 32'h11, 4'h3);
    av(0, 8'h0c, 32'h0, 4'hf);
    check(q, 32'h1fd);
    av(0, 8'h1c, 32'h0, 4'hf);
    check(q, 32'h0);
    av(1, 8'h14, 32'h1, 4'hf);
    for (int k = 0; k < 6; k++) begin
      run_frame(k % 4, k, 1'b0, 1'b0);
      run_frame((k + 1) % 4, k, 1'b1, 1'b0);
    end
    run_frame(2, 3, 1'b0, 1'b1);
    end_of_test();
  end
endmodule
